// ==== src/flash_self_program_control.sv ====
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns
// Functional notes
// - reset vector is 0x0000 when boot fuse is one, boot address when zero
// - software has no path to change any fuse
// - control register resets to zero; bit 5 reads zero
// - ready interrupt requested while enable, global flag set and program enable clear
// - erase or write to rww section sets busy flag; section then blocked
// - busy clears on re-enable after completion, or when page load starts
// - read enable with program enable then store re-enables section, refused while busy
// - writing read enable during page loading discards the buffer
// - lock set command programs lock bits from low work register
// - load within three cycles after lock set returns lock or fuse bits
// - page write command writes buffer to page from pointer upper bits
// - core halted during erase or write to the halting section
// - page erase command erases page from pointer upper bits
// - program enable alone loads work register pair into buffer word
// - program enable arms four cycles, auto-clears, stays high during operation
// - only five listed command patterns take effect
// - pointer built from low, high and extension bytes
// - target address latched when an operation starts
// - load after lock set selects the readback byte using pointer bits 1:0
// - buffer words may be written in any order
// - buffer clears after page write, re-enable and reset
// - eeprom write blocks programming and fuse/lock readback

module flash_self_program_control #(
   parameter int ADDR_W = 17,
   parameter int PAGE_WORDS_W = 7,
   parameter bit HAS_EXT = 1'b1,
   parameter int PROG_CNT = flash_spm_pkg::PROG_CYCLES,
   parameter logic [15:0] BOOT_RESET_ADDR = 16'hf000,
   parameter logic [15:0] HALTING_SECTION_START_WORD = 16'hf000,
   parameter logic [7:0] FUSE_LOW = 8'hff,
   parameter logic [7:0] FUSE_HIGH = 8'hff,
   parameter logic [7:0] FUSE_EXT = 8'hff
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic boot_reset_fuse,
   output logic [15:0] reset_vector,
   output logic ready_irq,
   output logic core_halt,
   output logic section_busy_flag,
   output logic flash_erase_pulse,
   output logic flash_write_pulse,
   output logic [ADDR_W-1:0] flash_target_addr
);

   localparam int PAGE_BITS = ADDR_W - 1 - PAGE_WORDS_W;
   localparam int DEPTH = 1 << PAGE_WORDS_W;

   // ****************************************************
   // state
   // ****************************************************
   logic [7:0] ctrl_ff;
   logic [7:0] ptr_ext_ff;
   logic [7:0] ptr_high_ff;
   logic [7:0] ptr_low_ff;
   logic [7:0] work_reg_low_ff;
   logic [7:0] work_reg_high_ff;
   logic gie_ff;
   logic ee_busy_ff;
   logic [7:0] readback_ff;
   logic [5:0] lock_bits_ff;
   logic [2:0] arm_cnt_ff;
   logic [31:0] prog_cnt_ff;
   logic halt_op_ff;
   logic loading_ff;
   logic reset_done_ff;
   flash_spm_pkg::seq_state_e state_ff;
   logic [15:0] buf_mem [DEPTH];
   logic [DEPTH-1:0] buf_valid_ff;

   flash_spm_pkg::pointer_s ptr;
   logic wr_acc;
   logic rd_acc;
   logic ctrl_wr;
   logic store_cmd;
   logic load_cmd;
   logic store_ok;
   logic [4:0] cmd;
   logic op_done;
   logic [ADDR_W-1:0] ptr_addr;

   // ****************************************************
   // decode
   // ****************************************************
   function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
      return a == off;
   endfunction : is_reg

   function automatic logic legal_cmd(input logic [4:0] c);
      return c == flash_spm_pkg::CMD_REENABLE || c == flash_spm_pkg::CMD_LOCK ||
         c == flash_spm_pkg::CMD_WRITE || c == flash_spm_pkg::CMD_ERASE ||
         c == flash_spm_pkg::CMD_LOAD;
   endfunction : legal_cmd

   always_comb begin
      ptr.ext = HAS_EXT ? ptr_ext_ff : 8'h00;
      ptr.high = ptr_high_ff;
      ptr.low = ptr_low_ff;
      ptr_addr = ADDR_W'(ptr);
   end

   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && !penable && !pwrite;
   assign ctrl_wr = wr_acc && is_reg(paddr, flash_spm_pkg::OFF_CTRL_STATUS);
   assign store_cmd = wr_acc && is_reg(paddr, flash_spm_pkg::OFF_CORE) &&
      pwdata[flash_spm_pkg::BIT_STORE];
   assign load_cmd = wr_acc && is_reg(paddr, flash_spm_pkg::OFF_CORE) &&
      pwdata[flash_spm_pkg::BIT_LOAD];
   assign cmd = ctrl_ff[4:0];
   assign store_ok = store_cmd && state_ff == flash_spm_pkg::ST_ARMED && !ee_busy_ff;
   assign op_done = state_ff == flash_spm_pkg::ST_BUSY && prog_cnt_ff == 32'd1;

   // ****************************************************
   // command sequencer
   // ****************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= flash_spm_pkg::CTRL_RESET;
         state_ff <= flash_spm_pkg::ST_IDLE;
         arm_cnt_ff <= 3'h0;
         prog_cnt_ff <= 32'h0;
         halt_op_ff <= 1'b0;
         flash_target_addr <= '0;
         flash_erase_pulse <= 1'b0;
         flash_write_pulse <= 1'b0;
         lock_bits_ff <= 6'h3f;
         loading_ff <= 1'b0;
      end else begin
         flash_erase_pulse <= 1'b0;
         flash_write_pulse <= 1'b0;
         unique case (state_ff)
            flash_spm_pkg::ST_IDLE: begin
               if (ctrl_wr && !ee_busy_ff && legal_cmd(pwdata[4:0])) begin
                  ctrl_ff[4:0] <= pwdata[4:0];
                  arm_cnt_ff <= 3'(flash_spm_pkg::ARM_CYCLES);
                  state_ff <= flash_spm_pkg::ST_ARMED;
                  if (pwdata[flash_spm_pkg::BIT_SEC_READ_EN] && loading_ff) begin
                     loading_ff <= 1'b0;
                  end
               end
            end
            flash_spm_pkg::ST_ARMED: begin
               if (store_ok) begin
                  unique case (cmd)
                     flash_spm_pkg::CMD_ERASE, flash_spm_pkg::CMD_WRITE: begin
                        flash_target_addr <= ptr_addr;
                        halt_op_ff <= ptr_addr[ADDR_W-1:1] >= (ADDR_W-1)'(HALTING_SECTION_START_WORD);
                        prog_cnt_ff <= 32'(PROG_CNT);
                        state_ff <= flash_spm_pkg::ST_BUSY;
                        flash_erase_pulse <= cmd == flash_spm_pkg::CMD_ERASE;
                        flash_write_pulse <= cmd == flash_spm_pkg::CMD_WRITE;
                     end
                     flash_spm_pkg::CMD_LOCK: begin
                        // only programs (clears) lock bits
                        lock_bits_ff <= lock_bits_ff & {work_reg_low_ff[5:2], 2'h3};
                        ctrl_ff[4:0] <= 5'h00;
                        state_ff <= flash_spm_pkg::ST_IDLE;
                     end
                     flash_spm_pkg::CMD_LOAD: begin
                        loading_ff <= 1'b1;
                        ctrl_ff[4:0] <= 5'h00;
                        state_ff <= flash_spm_pkg::ST_IDLE;
                     end
                     default: begin
                        loading_ff <= 1'b0;
                        ctrl_ff[4:0] <= 5'h00;
                        state_ff <= flash_spm_pkg::ST_IDLE;
                     end
                  endcase
               end else if (load_cmd && cmd == flash_spm_pkg::CMD_LOCK &&
                     arm_cnt_ff > 3'(flash_spm_pkg::ARM_CYCLES - flash_spm_pkg::READ_CYCLES)) begin
                  ctrl_ff[4:0] <= 5'h00;
                  state_ff <= flash_spm_pkg::ST_IDLE;
               end else if (arm_cnt_ff == 3'h1) begin
                  ctrl_ff[4:0] <= 5'h00;
                  state_ff <= flash_spm_pkg::ST_IDLE;
               end else begin
                  arm_cnt_ff <= arm_cnt_ff - 3'h1;
               end
            end
            flash_spm_pkg::ST_BUSY: begin
               prog_cnt_ff <= prog_cnt_ff - 32'h1;
               if (op_done) begin
                  if (cmd == flash_spm_pkg::CMD_WRITE) begin
                     loading_ff <= 1'b0;
                  end
                  ctrl_ff[4:0] <= 5'h00;
                  halt_op_ff <= 1'b0;
                  state_ff <= flash_spm_pkg::ST_IDLE;
               end
            end
            default: state_ff <= flash_spm_pkg::ST_IDLE;
         endcase
         if (ctrl_wr) begin
            ctrl_ff[flash_spm_pkg::BIT_READY_IE] <= pwdata[flash_spm_pkg::BIT_READY_IE];
         end
      end
   end

   // ****************************************************
   // section busy flag
   // ****************************************************
   logic sec_busy_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_busy_ff <= 1'b0;
      end else if (store_ok && (cmd == flash_spm_pkg::CMD_ERASE || cmd == flash_spm_pkg::CMD_WRITE) &&
            ptr_addr[ADDR_W-1:1] < (ADDR_W-1)'(HALTING_SECTION_START_WORD)) begin
         sec_busy_ff <= 1'b1;
      end else if (store_ok && (cmd == flash_spm_pkg::CMD_REENABLE ||
            cmd == flash_spm_pkg::CMD_LOAD)) begin
         sec_busy_ff <= 1'b0;
      end
   end

   // ****************************************************
   // page buffer
   // ****************************************************
   logic buf_clear;
   assign buf_clear = (op_done && cmd == flash_spm_pkg::CMD_WRITE) ||
      (store_ok && cmd == flash_spm_pkg::CMD_REENABLE) ||
      (ctrl_wr && pwdata[flash_spm_pkg::BIT_SEC_READ_EN] && loading_ff &&
      state_ff == flash_spm_pkg::ST_IDLE && !ee_busy_ff &&
      legal_cmd(pwdata[4:0]));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_valid_ff <= '0;
      end else if (buf_clear) begin
         buf_valid_ff <= '0;
      end else if (store_ok && cmd == flash_spm_pkg::CMD_LOAD) begin
         buf_valid_ff[ptr_addr[PAGE_WORDS_W:1]] <= 1'b1;
      end
   end

   always_ff @(posedge pclk) begin
      if (store_ok && cmd == flash_spm_pkg::CMD_LOAD) begin
         buf_mem[ptr_addr[PAGE_WORDS_W:1]] <= {work_reg_high_ff, work_reg_low_ff};
      end
   end

   // ****************************************************
   // pointer, work registers and core inputs
   // ****************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_ext_ff <= 8'h00;
         ptr_high_ff <= 8'h00;
         ptr_low_ff <= 8'h00;
         work_reg_low_ff <= 8'h00;
         work_reg_high_ff <= 8'h00;
         gie_ff <= 1'b0;
         ee_busy_ff <= 1'b0;
      end else if (wr_acc) begin
         if (is_reg(paddr, flash_spm_pkg::OFF_PTR_EXT) && HAS_EXT) begin
            ptr_ext_ff <= {7'h00, pwdata[0]};
         end
         if (is_reg(paddr, flash_spm_pkg::OFF_PTR_HIGH)) begin
            ptr_high_ff <= pwdata[7:0];
         end
         if (is_reg(paddr, flash_spm_pkg::OFF_PTR_LOW)) begin
            ptr_low_ff <= pwdata[7:0];
         end
         if (is_reg(paddr, flash_spm_pkg::OFF_WORK)) begin
            work_reg_low_ff <= pwdata[7:0];
            work_reg_high_ff <= pwdata[15:8];
         end
         if (is_reg(paddr, flash_spm_pkg::OFF_CORE)) begin
            gie_ff <= pwdata[flash_spm_pkg::BIT_GIE];
            ee_busy_ff <= pwdata[flash_spm_pkg::BIT_EE_BUSY];
         end
      end
   end

   // fuses are parameters/inputs only: no write path exists
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         readback_ff <= 8'h00;
      end else if (load_cmd && state_ff == flash_spm_pkg::ST_ARMED &&
            cmd == flash_spm_pkg::CMD_LOCK && !ee_busy_ff &&
            arm_cnt_ff > 3'(flash_spm_pkg::ARM_CYCLES - flash_spm_pkg::READ_CYCLES)) begin
         unique case (ptr_addr[1:0])
            2'h0: readback_ff <= FUSE_LOW;
            2'h1: readback_ff <= {2'h3, lock_bits_ff};
            2'h2: readback_ff <= FUSE_EXT;
            2'h3: readback_ff <= FUSE_HIGH;
         endcase
      end
   end

   // ****************************************************
   // outputs
   // ****************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_vector <= flash_spm_pkg::APP_RESET_ADDR;
         reset_done_ff <= 1'b0;
         ready_irq <= 1'b0;
         core_halt <= 1'b0;
         section_busy_flag <= 1'b0;
      end else begin
         if (!reset_done_ff) begin
            reset_vector <= boot_reset_fuse ? flash_spm_pkg::APP_RESET_ADDR : BOOT_RESET_ADDR;
            reset_done_ff <= 1'b1;
         end
         ready_irq <= ctrl_ff[flash_spm_pkg::BIT_READY_IE] && gie_ff &&
            !ctrl_ff[flash_spm_pkg::BIT_PROG_EN];
         core_halt <= state_ff == flash_spm_pkg::ST_BUSY && halt_op_ff && !op_done;
         section_busy_flag <= sec_busy_ff;
      end
   end

   // ****************************************************
   // apb read path
   // ****************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && paddr > flash_spm_pkg::OFF_STATUS;
         if (rd_acc) begin
            unique case (paddr)
               flash_spm_pkg::OFF_CTRL_STATUS:
                  prdata <= {24'h0, ctrl_ff[7], sec_busy_ff, 1'b0, ctrl_ff[4:0]};
               flash_spm_pkg::OFF_PTR_EXT: prdata <= {24'h0, ptr_ext_ff};
               flash_spm_pkg::OFF_PTR_HIGH: prdata <= {24'h0, ptr_high_ff};
               flash_spm_pkg::OFF_PTR_LOW: prdata <= {24'h0, ptr_low_ff};
               flash_spm_pkg::OFF_WORK: prdata <= {16'h0, work_reg_high_ff, work_reg_low_ff};
               flash_spm_pkg::OFF_CORE: prdata <= {28'h0, ee_busy_ff, gie_ff, 2'h0};
               flash_spm_pkg::OFF_READBACK: prdata <= {24'h0, readback_ff};
               flash_spm_pkg::OFF_STATUS: prdata <= {30'h0, loading_ff, core_halt};
               default: prdata <= 32'h0;
            endcase
         end
      end
   end

endmodule : flash_self_program_control

// ==== inc/flash_spm_pkg.sv ====
package flash_spm_pkg;

   // ****************************************************
   // register map (apb byte addresses)
   // ****************************************************
   localparam logic [11:0] OFF_CTRL_STATUS = 12'h000;
   localparam logic [11:0] OFF_PTR_EXT = 12'h004;
   localparam logic [11:0] OFF_PTR_HIGH = 12'h008;
   localparam logic [11:0] OFF_PTR_LOW = 12'h00c;
   localparam logic [11:0] OFF_WORK = 12'h010;
   localparam logic [11:0] OFF_CORE = 12'h014;
   localparam logic [11:0] OFF_READBACK = 12'h018;
   localparam logic [11:0] OFF_STATUS = 12'h01c;

   // ****************************************************
   // control register fields
   // ****************************************************
   localparam int BIT_PROG_EN = 0;
   localparam int BIT_PAGE_ERASE = 1;
   localparam int BIT_PAGE_WRITE = 2;
   localparam int BIT_LOCK_SET = 3;
   localparam int BIT_SEC_READ_EN = 4;
   localparam int BIT_SEC_BUSY = 6;
   localparam int BIT_READY_IE = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   localparam logic [4:0] CMD_REENABLE = 5'h11;
   localparam logic [4:0] CMD_LOCK = 5'h09;
   localparam logic [4:0] CMD_WRITE = 5'h05;
   localparam logic [4:0] CMD_ERASE = 5'h03;
   localparam logic [4:0] CMD_LOAD = 5'h01;

   // core command register fields (offset OFF_CORE)
   localparam int BIT_STORE = 0;
   localparam int BIT_LOAD = 1;
   localparam int BIT_GIE = 2;
   localparam int BIT_EE_BUSY = 3;

   // ****************************************************
   // timing
   // ****************************************************
   localparam int ARM_CYCLES = 4;
   localparam int READ_CYCLES = 3;
   localparam real CLK_NS = 10.0;
   localparam real PROG_TIME_NS = 40000.0;
   localparam int PROG_CYCLES = int'(PROG_TIME_NS / CLK_NS);
   localparam logic [15:0] APP_RESET_ADDR = 16'h0000;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARMED,
      ST_BUSY
   } seq_state_e;

   typedef struct packed {
      logic [7:0] ext;
      logic [7:0] high;
      logic [7:0] low;
   } pointer_s;

endpackage : flash_spm_pkg

// ==== testbench/flash_spm_chk.sv ====
`timescale 1ns/1ns
module flash_spm_chk #(
   parameter int ADDR_W = 17,
   parameter logic [15:0] BOOT_RESET_ADDR = 16'hf000,
   parameter logic [15:0] HALTING_SECTION_START_WORD = 16'hf000
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic boot_reset_fuse,
   input wire logic [15:0] reset_vector,
   input wire logic ready_irq,
   input wire logic core_halt,
   input wire logic section_busy_flag,
   input wire logic flash_erase_pulse,
   input wire logic flash_write_pulse,
   input wire logic [ADDR_W-1:0] flash_target_addr
);
   // ****************************************************
   // protocol and sequencer checks
   // ****************************************************
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic halt_page;
   logic op_start;
   assign halt_page = flash_target_addr[ADDR_W-1:1] >= HALTING_SECTION_START_WORD;
   assign op_start = flash_erase_pulse || flash_write_pulse;

   a_access_ready: assert property (psel && !penable |=> pready)
      else $error("no answer one cycle after setup");
   a_slverr_decode: assert property (pready |-> pslverr == (paddr > 12'h01c))
      else $error("slave error does not match address decode");
   a_vector_select: assert property ($rose(presetn) |=>
      reset_vector == (boot_reset_fuse ? 16'h0000 : BOOT_RESET_ADDR))
      else $error("reset vector does not follow boot fuse");
   a_vector_hold: assert property (!$rose(presetn) |=> $stable(reset_vector))
      else $error("reset vector moved outside reset release");
   a_reserved_zero: assert property (pready && !pwrite && paddr == 12'h000 |-> !prdata[5])
      else $error("reserved control bit reads one");
   a_halt_section: assert property (op_start ##1 halt_page |-> ##[0:2] core_halt)
      else $error("core not halted for halting section page");
   a_busy_start: assert property (op_start ##1 !halt_page |-> ##[0:2] section_busy_flag)
      else $error("busy flag not set for section page");
   a_pulse_single: assert property (flash_erase_pulse |=> !flash_erase_pulse && !flash_write_pulse)
      else $error("erase start pulse too long");
   a_irq_quiet: assert property (op_start |=> !ready_irq [*8])
      else $error("ready interrupt while operation runs");
   a_target_held: assert property (op_start |=> $stable(flash_target_addr) [*8])
      else $error("target address moved during operation");

   c_erase: cover property (flash_erase_pulse);
   c_write: cover property (flash_write_pulse);
   c_halt: cover property ($rose(core_halt));
endmodule : flash_spm_chk

// ==== testbench/flash_core_model.sv ====
`timescale 1ns/1ns
module flash_core_model (
   input wire logic pclk,
   input wire logic pready,
   input wire logic [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   // ****************************************************
   // core bus master, one or two chained transfers
   // ****************************************************
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end

   task automatic xfer(input logic w, input logic [11:0] a0, input logic [31:0] d0,
      input logic [11:0] a1, input logic [31:0] d1, input bit two, output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a0;
      pwdata <= d0;
      for (int i = 0; i <= int'(two); i++) begin
         @(posedge pclk);
         penable <= 1'b1;
         do begin
            @(posedge pclk);
         end while (pready !== 1'b1);
         q = prdata;
         if (i < int'(two)) begin
            // second transfer follows at once to stay inside the arm window
            penable <= 1'b0;
            paddr <= a1;
            pwdata <= d1;
         end else begin
            psel <= 1'b0;
            penable <= 1'b0;
            paddr <= ~paddr;
            pwdata <= ~pwdata;
         end
      end
   endtask : xfer
endmodule : flash_core_model

// ==== testbench/flash_self_program_control_test.sv ====
`timescale 1ns/1ns
module flash_self_program_control_test;
   // ****************************************************
   // design, partner and scoreboard
   // ****************************************************
   localparam logic [15:0] BOOT_ADDR = 16'he000;
   typedef struct packed {logic [31:0] v; logic [31:0] m;} exp_s;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic boot_reset_fuse = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, ready_irq, core_halt, section_busy_flag;
   logic flash_erase_pulse, flash_write_pulse;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, core;
   logic [15:0] reset_vector;
   logic [16:0] flash_target_addr;
   logic [7:0] c;
   int failures = 0, tests_run = 0, ers_n = 0, wrs_n = 0, e0, w0;
   integer seed = 32'h482a;
   exp_s exp_q[$];
   exp_s e;

   always #5 pclk = ~pclk;

   flash_self_program_control #(.PROG_CNT(20), .BOOT_RESET_ADDR(BOOT_ADDR), .FUSE_LOW(8'h5a),
      .FUSE_HIGH(8'ha5)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .boot_reset_fuse(boot_reset_fuse),
      .reset_vector(reset_vector), .ready_irq(ready_irq), .core_halt(core_halt),
      .section_busy_flag(section_busy_flag), .flash_erase_pulse(flash_erase_pulse),
      .flash_write_pulse(flash_write_pulse), .flash_target_addr(flash_target_addr));

   flash_core_model i_core (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
      tests_run++;
      if (seen !== expv) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask : chk

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      i_core.xfer(1'b1, a, d, a, d, 1'b0, q);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m);
      exp_q.push_back('{v, m});
      i_core.xfer(1'b0, a, 32'h0, a, 32'h0, 1'b0, q);
   endtask : rd

   task automatic rc(input logic [31:0] v, input logic [31:0] m);
      rd(flash_spm_pkg::OFF_CTRL_STATUS, v, m);
   endtask : rc

   // control write chained with a store (s=1) or load (s=2)
   task automatic cmd(input logic [7:0] cv, input logic [31:0] s);
      i_core.xfer(1'b1, flash_spm_pkg::OFF_CTRL_STATUS, {24'h0, cv}, flash_spm_pkg::OFF_CORE,
         core | s, 1'b1, q);
   endtask : cmd

   task automatic wait_idle();
      do begin
         rc(32'h0, 32'h0);
      end while (q[0] !== 1'b0);
   endtask : wait_idle

   always @(posedge pclk) begin
      if (flash_erase_pulse === 1'b1) ers_n++;
      if (flash_write_pulse === 1'b1) wrs_n++;
      if (presetn && psel && penable && pready === 1'b1) begin
         chk({31'h0, pslverr}, {31'h0, paddr > 12'h01c});
         if (!pwrite && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk(prdata & e.m, e.v & e.m);
         end
      end
   end

   initial begin
      #500000;
      failures++;
      test_done();
   end

   // ****************************************************
   // scenarios
   // ****************************************************
   initial begin
      core = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rc(32'h0, 32'hff);
      chk({16'h0, reset_vector}, 32'h0);
      rd(12'h020, 32'h0, 32'h0);
      $display("test reset done");
      wr(flash_spm_pkg::OFF_PTR_LOW, 32'h2);
      cmd(8'h01, 32'h1);
      rc(32'h0, 32'h3f);
      rd(flash_spm_pkg::OFF_STATUS, 32'h2, 32'h2);
      wr(flash_spm_pkg::OFF_CTRL_STATUS, 32'h11);
      rd(flash_spm_pkg::OFF_STATUS, 32'h0, 32'h2);
      $display("test buffer load done");
      wr(flash_spm_pkg::OFF_PTR_LOW, 32'h0);
      wr(flash_spm_pkg::OFF_PTR_HIGH, 32'h10);
      e0 = ers_n;
      cmd(8'h03, 32'h1);
      wr(flash_spm_pkg::OFF_PTR_HIGH, 32'h20);
      rc(32'h43, 32'h7f);
      cmd(8'h11, 32'h1);
      rc(32'h43, 32'h7f);
      wait_idle();
      chk(ers_n, e0 + 1);
      chk({15'h0, flash_target_addr}, 32'h01000);
      rc(32'h40, 32'h7f);
      cmd(8'h11, 32'h1);
      rc(32'h0, 32'h7f);
      wr(flash_spm_pkg::OFF_PTR_HIGH, 32'h10);
      w0 = wrs_n;
      cmd(8'h05, 32'h1);
      rc(32'h45, 32'h7f);
      wait_idle();
      chk(wrs_n, w0 + 1);
      cmd(8'h11, 32'h1);
      $display("test erase and write done");
      wr(flash_spm_pkg::OFF_PTR_EXT, 32'h1);
      wr(flash_spm_pkg::OFF_PTR_HIGH, 32'he0);
      cmd(8'h03, 32'h1);
      rd(flash_spm_pkg::OFF_STATUS, 32'h1, 32'h1);
      rc(32'h03, 32'h43);
      wait_idle();
      chk({15'h0, flash_target_addr}, 32'h1e000);
      wr(flash_spm_pkg::OFF_PTR_EXT, 32'h0);
      $display("test halting section done");
      e0 = ers_n;
      w0 = wrs_n;
      cmd(8'h00, 32'h1);
      for (int i = 0; i < 12; i++) begin
         c = 8'($random(seed));
         c[7:5] = 3'h0;
         if (c[4:0] inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01}) c[4:0] = 5'h1f;
         cmd(c, 32'h1);
      end
      chk(ers_n, e0);
      chk(wrs_n, w0);
      rc(32'h0, 32'h3f);
      $display("test illegal patterns done");
      for (int i = 0; i < 2; i++) begin
         wr(flash_spm_pkg::OFF_PTR_LOW, i ? 32'h3 : 32'h0);
         cmd(8'h09, 32'h2);
         rd(flash_spm_pkg::OFF_READBACK, i ? 32'ha5 : 32'h5a, 32'hff);
      end
      wr(flash_spm_pkg::OFF_WORK, 32'hf0);
      cmd(8'h09, 32'h1);
      wr(flash_spm_pkg::OFF_PTR_LOW, 32'h1);
      cmd(8'h09, 32'h2);
      rd(flash_spm_pkg::OFF_READBACK, 32'hf3, 32'hff);
      core = 32'h8;
      wr(flash_spm_pkg::OFF_CORE, core);
      cmd(8'h03, 32'h1);
      repeat (25) @(posedge pclk);
      chk(ers_n, e0);
      rc(32'h0, 32'h3f);
      core = 32'h4;
      wr(flash_spm_pkg::OFF_CORE, core);
      wr(flash_spm_pkg::OFF_CTRL_STATUS, 32'h80);
      repeat (2) @(posedge pclk);
      chk({31'h0, ready_irq}, 32'h1);
      wr(flash_spm_pkg::OFF_CTRL_STATUS, 32'h81);
      repeat (2) @(posedge pclk);
      chk({31'h0, ready_irq}, 32'h0);
      repeat (6) @(posedge pclk);
      chk({31'h0, ready_irq}, 32'h1);
      cmd(8'h83, 32'h1);
      chk({31'h0, ready_irq}, 32'h0);
      wait_idle();
      chk({31'h0, ready_irq}, 32'h1);
      $display("test readback and interrupt done");
      @(posedge pclk);
      presetn <= 1'b0;
      boot_reset_fuse <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({16'h0, reset_vector}, {16'h0, BOOT_ADDR});
      rc(32'h0, 32'hff);
      $display("test boot fuse done");
      test_done();
   end
endmodule : flash_self_program_control_test

bind flash_self_program_control flash_spm_chk #(.ADDR_W(ADDR_W),
   .BOOT_RESET_ADDR(BOOT_RESET_ADDR), .HALTING_SECTION_START_WORD(HALTING_SECTION_START_WORD)) i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .boot_reset_fuse(boot_reset_fuse), .reset_vector(reset_vector), .ready_irq(ready_irq),
   .core_halt(core_halt), .section_busy_flag(section_busy_flag),
   .flash_erase_pulse(flash_erase_pulse), .flash_write_pulse(flash_write_pulse),
   .flash_target_addr(flash_target_addr));
